/* rtl/ssf_params.svh */
// offsets, field positions, reset values and encodings for the serial port status flags block
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SSF_OFS_CTRL        8'h00
`define SSF_OFS_OWN_ADDR    8'h04
`define SSF_OFS_BUFFER      8'h08
`define SSF_OFS_IRQ_STATUS  8'h0c
`define SSF_OFS_IRQ_MASK    8'h10
`define SSF_OFS_STATUS      8'h94

// ************************************************************
// serial_port_status field positions
// ************************************************************
`define SSF_ST_SAMPLE_PHASE 7
`define SSF_ST_CLOCK_EDGE   6
`define SSF_ST_DATA_ADDR    5
`define SSF_ST_HALT         4
`define SSF_ST_BEGIN        3
`define SSF_ST_READ_WRITE   2
`define SSF_ST_ADDR_UPDATE  1
`define SSF_ST_BUF_FULL     0
`define SSF_ST_WR_MASK      8'hc0

// ************************************************************
// control, interrupt fields
// ************************************************************
`define SSF_CTRL_PORT_EN    0
`define SSF_CTRL_TWO_WIRE   1
`define SSF_IRQ_BEGIN       0
`define SSF_IRQ_HALT        1
`define SSF_IRQ_BYTE        2

// ************************************************************
// reset values and counts
// ************************************************************
`define SSF_RST_STATUS      8'h00
`define SSF_RST_CTRL        2'h0
`define SSF_RST_OWN_ADDR    7'h00
`define SSF_RST_IRQ         3'h0
`define SSF_BITS_PER_BYTE   4'h8
`define SSF_LAST_DATA_BIT   4'h7

`endif

/* rtl/ssf_pkg.sv */
// types shared by the serial port status flags block
package ssf_pkg;

   typedef enum logic [2:0] {
      SSF_IDLE = 3'b000,
      SSF_ADDR = 3'b001,
      SSF_RX   = 3'b010,
      SSF_TX   = 3'b011,
      SSF_SKIP = 3'b100
   } ssf_link_state_t;

endpackage : ssf_pkg

/* rtl/ssf_cond_detect.sv */
// pin synchroniser with clock edge and start / stop condition detection
module ssf_cond_detect (
   input  wire logic clk_sys,    // system clock
   input  wire logic rst,        // synchronous reset, active high
   input  wire logic scl_in,     // clock pin level
   input  wire logic sda_in,     // data pin level
   output logic      scl_lvl,    // synchronised clock level
   output logic      sda_lvl,    // synchronised data level
   output logic      scl_rise,   // one-cycle pulse on clock rise
   output logic      scl_fall,   // one-cycle pulse on clock fall
   output logic      begin_seen, // one-cycle pulse on start condition
   output logic      halt_seen   // one-cycle pulse on stop condition
);

   logic [1:0] scl_meta;
   logic [1:0] sda_meta;
   logic       scl_prev;
   logic       sda_prev;
   logic [1:0] next_scl_meta;
   logic [1:0] next_sda_meta;

   // ************************************************************
   // two-stage synchronisers plus one history stage
   // ************************************************************
   always_comb begin
      next_scl_meta = {scl_meta[0], scl_in};
      next_sda_meta = {sda_meta[0], sda_in};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_meta <= 2'h3;
         sda_meta <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_meta <= next_scl_meta;
         sda_meta <= next_sda_meta;
         scl_prev <= scl_meta[1];
         sda_prev <= sda_meta[1];
      end
   end

   // only the second stage and the history stage are looked at
   assign scl_lvl    = scl_meta[1];
   assign sda_lvl    = sda_meta[1];
   assign scl_rise   = scl_meta[1] & ~scl_prev;
   assign scl_fall   = ~scl_meta[1] & scl_prev;
   assign begin_seen = scl_meta[1] & scl_prev & sda_prev & ~sda_meta[1];
   assign halt_seen  = scl_meta[1] & scl_prev & ~sda_prev & sda_meta[1];

endmodule : ssf_cond_detect

/* rtl/ssf_status_top.sv */
// serial port status register with two-wire slave tracking and AHB-Lite register access
`include "ssf_params.svh"

module ssf_status_top import ssf_pkg::*; (
   input  wire logic        clk_sys,   // system clock, 20 MHz
   input  wire logic        rst,       // synchronous reset, active high
   input  wire logic        hsel,      // ahb slave select
   input  wire logic [31:0] haddr,     // ahb address
   input  wire logic [1:0]  htrans,    // ahb transfer type
   input  wire logic        hwrite,    // ahb write
   input  wire logic [2:0]  hsize,     // ahb size, word only
   input  wire logic [31:0] hwdata,    // ahb write data
   input  wire logic        hready,    // ahb bus ready
   output logic             hreadyout, // ahb slave ready
   output logic [31:0]      hrdata,    // ahb read data
   output logic             hresp,     // ahb response, always okay
   input  wire logic        scl_in,    // two-wire clock pin
   input  wire logic        sda_in,    // two-wire data pin
   output logic             sda_out,   // data pin drive level, always low
   output logic             sda_oe,    // data pin pull-low enable
   output logic             irq        // level interrupt
);

   // ************************************************************
   // state
   // ************************************************************
   logic            dp_valid;
   logic [7:0]      dp_addr;
   logic            dp_write;
   logic [1:0]      ctrl;
   logic [6:0]      own_address;
   logic [7:0]      serial_buffer;
   logic [7:0]      status;
   logic [2:0]      irq_status;
   logic [2:0]      irq_mask;
   ssf_link_state_t link_state;
   logic [3:0]      bit_cnt;
   logic [7:0]      rx_shift;
   logic [7:0]      tx_shift;
   logic            acking;

   logic            next_dp_valid;
   logic [7:0]      next_dp_addr;
   logic            next_dp_write;
   logic            next_hreadyout;
   logic [31:0]     next_hrdata;
   logic [1:0]      next_ctrl;
   logic [6:0]      next_own_address;
   logic [7:0]      next_serial_buffer;
   logic [7:0]      next_status;
   logic [2:0]      next_irq_status;
   logic [2:0]      next_irq_mask;
   logic            next_irq;
   ssf_link_state_t next_link_state;
   logic [3:0]      next_bit_cnt;
   logic [7:0]      next_rx_shift;
   logic [7:0]      next_tx_shift;
   logic            next_acking;
   logic            next_sda_oe;

   // only the clock edges matter here, its synchronised level is left unconnected
   logic            sda_lvl;
   logic            scl_rise;
   logic            scl_fall;
   logic            begin_seen;
   logic            halt_seen;
   logic            port_en;
   logic            take;
   logic [7:0]      byte_in;
   logic [2:0]      events;

   ssf_cond_detect u_cond (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .scl_lvl    (),
      .sda_lvl    (sda_lvl),
      .scl_rise   (scl_rise),
      .scl_fall   (scl_fall),
      .begin_seen (begin_seen),
      .halt_seen  (halt_seen)
   );

   assign port_en = ctrl[`SSF_CTRL_PORT_EN] & ctrl[`SSF_CTRL_TWO_WIRE];
   assign take    = hsel & htrans[1] & hready;
   assign byte_in = {rx_shift[6:0], sda_lvl};

   // ************************************************************
   // next-state logic: bus access first, link events after so a link update wins
   // ************************************************************
   always_comb begin
      next_dp_valid      = dp_valid;
      next_dp_addr       = dp_addr;
      next_dp_write      = dp_write;
      next_hreadyout     = hreadyout;
      next_hrdata        = hrdata;
      next_ctrl          = ctrl;
      next_own_address   = own_address;
      next_serial_buffer = serial_buffer;
      next_status        = status;
      next_irq_status    = irq_status;
      next_irq_mask      = irq_mask;
      next_link_state    = link_state;
      next_bit_cnt       = bit_cnt;
      next_rx_shift      = rx_shift;
      next_tx_shift      = tx_shift;
      next_acking        = acking;
      next_sda_oe        = sda_oe;
      events             = `SSF_RST_IRQ;

      // one wait state per transfer keeps read data coming from a flop
      if (dp_valid) begin
         next_dp_valid  = 1'b0;
         next_hreadyout = 1'b1;
         if (dp_write) begin
            case (dp_addr)
               `SSF_OFS_CTRL:       next_ctrl = hwdata[1:0];
               `SSF_OFS_OWN_ADDR:   next_own_address = hwdata[6:0];
               `SSF_OFS_BUFFER: begin
                  next_serial_buffer                 = hwdata[7:0];
                  next_status[`SSF_ST_BUF_FULL]      = 1'b1;
               end
               `SSF_OFS_STATUS: begin
                  // lower six bits are read-only
                  next_status = (hwdata[7:0] & `SSF_ST_WR_MASK) | (status & ~`SSF_ST_WR_MASK);
               end
               `SSF_OFS_IRQ_STATUS: next_irq_status = irq_status & ~hwdata[2:0];
               `SSF_OFS_IRQ_MASK:   next_irq_mask = hwdata[2:0];
               default: ;
            endcase
         end else begin
            case (dp_addr)
               `SSF_OFS_CTRL:       next_hrdata = {30'h0, ctrl};
               `SSF_OFS_OWN_ADDR:   next_hrdata = {25'h0, own_address};
               `SSF_OFS_BUFFER: begin
                  next_hrdata                   = {24'h0, serial_buffer};
                  next_status[`SSF_ST_BUF_FULL] = 1'b0;
               end
               `SSF_OFS_STATUS:     next_hrdata = {24'h0, status};
               `SSF_OFS_IRQ_STATUS: next_hrdata = {29'h0, irq_status};
               `SSF_OFS_IRQ_MASK:   next_hrdata = {29'h0, irq_mask};
               default:             next_hrdata = 32'h0;
            endcase
         end
      end else if (take) begin
         next_dp_valid  = 1'b1;
         next_dp_addr   = haddr[7:0];
         next_dp_write  = hwrite;
         next_hreadyout = 1'b0;
      end

      // ************************************************************
      // two-wire slave tracking
      // ************************************************************
      if (!port_en) begin
         next_link_state = SSF_IDLE;
         next_bit_cnt    = 4'h0;
         next_acking     = 1'b0;
         next_sda_oe     = 1'b0;
         next_status[`SSF_ST_HALT]       = 1'b0;
         next_status[`SSF_ST_BEGIN]      = 1'b0;
         next_status[`SSF_ST_READ_WRITE] = 1'b0;
         next_status[`SSF_ST_DATA_ADDR]  = 1'b0;
         next_status[`SSF_ST_BUF_FULL]   = 1'b0;
      end else if (begin_seen) begin
         next_status[`SSF_ST_BEGIN]      = 1'b1;
         next_status[`SSF_ST_HALT]       = 1'b0;
         next_status[`SSF_ST_READ_WRITE] = 1'b0;
         next_link_state = SSF_ADDR;
         next_bit_cnt    = 4'h0;
         next_acking     = 1'b0;
         next_sda_oe     = 1'b0;
         events[`SSF_IRQ_BEGIN] = 1'b1;
      end else if (halt_seen) begin
         next_status[`SSF_ST_HALT]       = 1'b1;
         next_status[`SSF_ST_BEGIN]      = 1'b0;
         next_status[`SSF_ST_READ_WRITE] = 1'b0;
         next_link_state = SSF_IDLE;
         next_bit_cnt    = 4'h0;
         next_acking     = 1'b0;
         next_sda_oe     = 1'b0;
         events[`SSF_IRQ_HALT] = 1'b1;
      end else if (scl_rise && link_state != SSF_IDLE) begin
         if (bit_cnt < `SSF_BITS_PER_BYTE) begin
            next_rx_shift = byte_in;
            next_tx_shift = {tx_shift[6:0], 1'b0};
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == `SSF_LAST_DATA_BIT) begin
               case (link_state)
                  SSF_ADDR: begin
                     if (byte_in[7:1] == own_address) begin
                        next_status[`SSF_ST_READ_WRITE] = byte_in[0];
                        next_status[`SSF_ST_DATA_ADDR]  = 1'b0;
                        next_status[`SSF_ST_BUF_FULL]   = 1'b1;
                        next_serial_buffer = byte_in;
                        next_acking        = 1'b1;
                        events[`SSF_IRQ_BYTE] = 1'b1;
                     end else begin
                        next_link_state = SSF_SKIP;
                     end
                  end
                  SSF_RX: begin
                     next_serial_buffer = byte_in;
                     next_status[`SSF_ST_BUF_FULL]  = 1'b1;
                     next_status[`SSF_ST_DATA_ADDR] = 1'b1;
                     next_acking        = 1'b1;
                     events[`SSF_IRQ_BYTE] = 1'b1;
                  end
                  SSF_TX: begin
                     next_status[`SSF_ST_DATA_ADDR] = 1'b1;
                     events[`SSF_IRQ_BYTE] = 1'b1;
                  end
                  default: ;
               endcase
            end
         end else begin
            // ninth clock: acknowledge slot
            next_bit_cnt = 4'h0;
            next_acking  = 1'b0;
            case (link_state)
               SSF_ADDR: begin
                  if (status[`SSF_ST_READ_WRITE]) begin
                     next_link_state = SSF_TX;
                     next_tx_shift   = serial_buffer;
                     next_status[`SSF_ST_BUF_FULL] = 1'b0;
                  end else begin
                     next_link_state = SSF_RX;
                  end
               end
               SSF_TX: begin
                  if (sda_lvl) begin
                     // master declined: drop back and wait for a new start
                     next_link_state = SSF_IDLE;
                     next_status[`SSF_ST_READ_WRITE] = 1'b0;
                     next_status[`SSF_ST_DATA_ADDR]  = 1'b0;
                     next_status[`SSF_ST_BUF_FULL]   = 1'b0;
                  end else begin
                     next_tx_shift = serial_buffer;
                     next_status[`SSF_ST_BUF_FULL] = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end else if (scl_fall) begin
         // no clock stretching: software must reload the buffer within one bit time
         if (bit_cnt == `SSF_BITS_PER_BYTE && acking) begin
            next_sda_oe = 1'b1;
         end else if (link_state == SSF_TX && bit_cnt < `SSF_BITS_PER_BYTE) begin
            next_sda_oe = ~tx_shift[7];
         end else begin
            next_sda_oe = 1'b0;
         end
      end

      // hardware events win over a same-cycle write-one clear
      next_irq_status = next_irq_status | events;
      next_irq        = |(next_irq_status & next_irq_mask);
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dp_valid      <= 1'b0;
         dp_addr       <= 8'h00;
         dp_write      <= 1'b0;
         hreadyout     <= 1'b1;
         hrdata        <= 32'h0;
         hresp         <= 1'b0;
         ctrl          <= `SSF_RST_CTRL;
         own_address   <= `SSF_RST_OWN_ADDR;
         serial_buffer <= 8'h00;
         status        <= `SSF_RST_STATUS;
         irq_status    <= `SSF_RST_IRQ;
         irq_mask      <= `SSF_RST_IRQ;
         irq           <= 1'b0;
         link_state    <= SSF_IDLE;
         bit_cnt       <= 4'h0;
         rx_shift      <= 8'h00;
         tx_shift      <= 8'h00;
         acking        <= 1'b0;
         sda_oe        <= 1'b0;
         sda_out       <= 1'b0;
      end else begin
         dp_valid      <= next_dp_valid;
         dp_addr       <= next_dp_addr;
         dp_write      <= next_dp_write;
         hreadyout     <= next_hreadyout;
         hrdata        <= next_hrdata;
         hresp         <= 1'b0;
         ctrl          <= next_ctrl;
         own_address   <= next_own_address;
         serial_buffer <= next_serial_buffer;
         status        <= next_status;
         irq_status    <= next_irq_status;
         irq_mask      <= next_irq_mask;
         irq           <= next_irq;
         link_state    <= next_link_state;
         bit_cnt       <= next_bit_cnt;
         rx_shift      <= next_rx_shift;
         tx_shift      <= next_tx_shift;
         acking        <= next_acking;
         sda_oe        <= next_sda_oe;
         sda_out       <= 1'b0;
      end
   end

endmodule : ssf_status_top

/* verif/ssf_chk.sv */
// assertion checker for the serial port status flags block
module ssf_chk (
   input wire logic        clk_sys,   // clock
   input wire logic        rst,       // sync reset
   input wire logic        hsel,      // select
   input wire logic [31:0] haddr,     // address
   input wire logic [1:0]  htrans,    // transfer type
   input wire logic        hwrite,    // write
   input wire logic [2:0]  hsize,     // size
   input wire logic [31:0] hwdata,    // write data
   input wire logic        hready,    // bus ready
   input wire logic        hreadyout, // slave ready
   input wire logic [31:0] hrdata,    // read data
   input wire logic        hresp,     // response
   input wire logic        scl_in,    // clock pin
   input wire logic        sda_in,    // data pin
   input wire logic        sda_out,   // data drive level
   input wire logic        sda_oe,    // data pull enable
   input wire logic        irq        // interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       tk;
   logic       wr_st;
   logic       next_wr_st;
   logic [1:0] top;
   logic [1:0] next_top;
   assign tk = hsel & htrans[1] & hready;
   // shadow of the two writable status bits, taken in the write data phase
   always_comb begin
      next_wr_st = tk & hwrite & (haddr[7:0] == 8'h94);
      next_top   = wr_st ? hwdata[7:6] : top;
   end
   always_ff @(posedge clk_sys) begin
      wr_st <= rst ? 1'b0 : next_wr_st;
      top   <= rst ? 2'h0 : next_top;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_wait; tk |=> !hreadyout ##1 hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("wait state wrong");
   property p_top; tk && !hwrite && haddr[7:0] == 8'h94 |=> ##1 hrdata[7:6] == top; endproperty
   a_top: assert property (p_top) else $error("writable status bits lost");
   property p_upper; tk && !hwrite |=> ##1 hrdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_unmap;
      tk && !hwrite && !(haddr[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h94}) |=> ##1 hrdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_rst; $past(rst) |-> hreadyout && !irq && !sda_oe && hrdata == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_okay; hreadyout |-> !hresp; endproperty
   a_okay: assert property (p_okay) else $error("error response seen");
   property p_drive; !sda_out; endproperty
   a_drive: assert property (p_drive) else $error("data pin driven high");
   property p_oe_scl; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("data pin moved with clock high");
   property p_oe_hold; $rose(sda_oe) |-> sda_oe[*4]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("data pull too short");
endmodule : ssf_chk

bind ssf_status_top ssf_chk u_chk (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

/* verif/ssf_tw_master.sv */
// behavioural two-wire bus master on the far side of the status block
module ssf_tw_master (
   input  wire logic clk_sys, // system clock
   input  wire logic sda_bus, // resolved data line
   output logic      scl,     // clock line, stands high between frames
   output logic      sda_low  // pulls the data line low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // ten clocks a phase, well above the detection floor
   task automatic hp;
      repeat (10) @(posedge clk_sys);
   endtask : hp
   task automatic tw_start;
      sda_low <= 1'b0;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b1;
      hp();
      scl <= 1'b0;
      hp();
   endtask : tw_start
   task automatic tw_stop;
      sda_low <= 1'b1;
      hp();
      scl <= 1'b1;
      hp();
      sda_low <= 1'b0;
      hp();
   endtask : tw_stop
   task automatic tw_bit(input logic b, output logic s);
      sda_low <= !b;
      hp();
      scl <= 1'b1;
      hp();
      s = sda_bus;
      scl <= 1'b0;
      hp();
   endtask : tw_bit
   task automatic tw_bits(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) tw_bit(b[i], s);
   endtask : tw_bits
   task automatic tw_byte(input logic [7:0] b, output logic ak);
      logic s;
      tw_bits(b);
      tw_bit(1'b1, s);
      ak = !s;
   endtask : tw_byte
   task automatic tw_rd(output logic [7:0] d, input logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) tw_bit(1'b1, d[i]);
      tw_bit(nack, s);
   endtask : tw_rd
endmodule : ssf_tw_master

/* verif/ssf_tb.sv */
// self-checking testbench for the serial port status flags block
`include "ssf_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp;
   logic        sda_out, sda_oe, irq, scl, m_low, sda_bus, ak;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  v;
   logic [31:0] haddr, hwdata, hrdata, r;
   int          fails, check_count;
   assign sda_bus = !(sda_oe | m_low);
   always #25 clk_sys = !clk_sys;
   ssf_status_top dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq));
   ssf_tw_master mst (.clk_sys(clk_sys), .sda_bus(sda_bus), .scl(scl), .sda_low(m_low));
   // ****************
   // bus tasks
   // ****************
   // no cycle count is assumed: only the watchdog ends a wait that never completes
   task automatic wrdy;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
         @(posedge clk_sys);
      end
   endtask : wrdy
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wrdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wrdy();
      r = hrdata;
   endtask : ahb
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      ahb(1'b0, a, 32'h0);
      cmp(r & m, e);
   endtask : chk
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk_sys);
      cmp({31'h0, irq}, {31'h0, e});
   endtask : irq_is
   task automatic results;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // ****************
   // sequence
   // ****************
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(`SSF_OFS_STATUS, 32'h0, 32'hffffffff);
      ahb(1'b1, `SSF_OFS_STATUS, 32'hff);
      chk(`SSF_OFS_STATUS, 32'hc0, 32'hffffffff);
      ahb(1'b1, 8'h20, 32'hff);
      chk(8'h20, 32'h0, 32'hffffffff);
      ahb(1'b1, `SSF_OFS_STATUS, 32'h0);
      ahb(1'b1, `SSF_OFS_OWN_ADDR, 32'h2a);
      ahb(1'b1, `SSF_OFS_IRQ_MASK, 32'h1);
      ahb(1'b1, `SSF_OFS_CTRL, 32'h3);
      chk(`SSF_OFS_STATUS, 32'h0, 32'h18);
      mst.tw_start();
      cmp({31'h0, irq}, 32'h1);
      chk(`SSF_OFS_STATUS, 32'h08, 32'h1c);
      ahb(1'b1, `SSF_OFS_IRQ_STATUS, 32'h1);
      irq_is(1'b0);
      mst.tw_byte(8'h54, ak);
      cmp({31'h0, ak}, 32'h1);
      chk(`SSF_OFS_STATUS, 32'h09, 32'h2f);
      chk(`SSF_OFS_BUFFER, 32'h54, 32'hff);
      chk(`SSF_OFS_STATUS, 32'h0, 32'h01);
      mst.tw_byte(8'ha5, ak);
      chk(`SSF_OFS_STATUS, 32'h29, 32'h2f);
      chk(`SSF_OFS_BUFFER, 32'ha5, 32'hff);
      ahb(1'b1, `SSF_OFS_IRQ_MASK, 32'h0);
      mst.tw_stop();
      chk(`SSF_OFS_STATUS, 32'h10, 32'h1c);
      irq_is(1'b0);
      ahb(1'b1, `SSF_OFS_IRQ_MASK, 32'h2);
      irq_is(1'b1);
      ahb(1'b1, `SSF_OFS_IRQ_STATUS, 32'h7);
      irq_is(1'b0);
      mst.tw_start();
      chk(`SSF_OFS_STATUS, 32'h08, 32'h1c);
      // foreign address must be ignored
      mst.tw_byte(8'h40, ak);
      cmp({31'h0, ak}, 32'h0);
      chk(`SSF_OFS_STATUS, 32'h0, 32'h05);
      mst.tw_start();
      mst.tw_bits(8'h55);
      ahb(1'b1, `SSF_OFS_BUFFER, 32'h3c);
      chk(`SSF_OFS_STATUS, 32'h05, 32'h05);
      mst.tw_bit(1'b1, ak);
      cmp({31'h0, ak}, 32'h0);
      mst.tw_rd(v, 1'b1);
      cmp({24'h0, v}, 32'h3c);
      chk(`SSF_OFS_STATUS, 32'h0, 32'h25);
      mst.tw_stop();
      ahb(1'b1, `SSF_OFS_CTRL, 32'h0);
      chk(`SSF_OFS_STATUS, 32'h0, 32'h3f);
      results();
   end
   // a hung handshake or frame is cut short here
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      results();
   end
endmodule : testbench
